/* hdl/prc_cell.sv */
// one pin register cell: five registers with clear, preset, inversion
`timescale 1ns/1ps
module prc_cell
  import prc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input prc_cfg_t cfg,
  input prc_ctl_t ctl,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic din_a,
  output logic din_b
);

  // ************************************************************
  // local polarity and io clock edges
  // ************************************************************
  logic clk_lvl;
  logic clr_act;
  logic ce_in;
  logic ce_out;
  logic oe_drive;
  logic dout_a;
  logic dout_b;
  logic prev_clk_ff;
  logic rise;
  logic fall;
  logic out_b_ff;

  assign clk_lvl = ctl.clk ^ cfg.inv.clk;
  assign clr_act = ctl.clr ^ cfg.inv.clr;
  assign ce_in = ctl.ce_in ^ cfg.inv.ce;
  assign ce_out = ctl.ce_out ^ cfg.inv.ce;
  assign dout_a = ctl.dout_a ^ cfg.inv.dout_a;
  assign dout_b = ctl.dout_b ^ cfg.inv.dout_b;
  // driver enable after tristate sense and mode
  assign oe_drive = cfg.mode[1] & (ctl.oe ^ cfg.inv.oe ^ cfg.oe_low);
  assign rise = clk_lvl & ~prev_clk_ff;
  assign fall = ~clk_lvl & prev_clk_ff;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      prev_clk_ff <= 1'b0;
    else
      prev_clk_ff <= clk_lvl;
  end

  // ************************************************************
  // four of the five cell registers; pin_oe follows below
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      din_a <= 1'b0;
      din_b <= 1'b0;
      pin_o <= 1'b0;
      out_b_ff <= 1'b0;
    end
    else if (clr_act)
    begin
      // one clear line, clear or preset per cell
      din_a <= cfg.preset;
      din_b <= cfg.preset;
      pin_o <= cfg.preset;
      out_b_ff <= cfg.preset;
    end
    else if (rise)
    begin
      if (cfg.sync_rst)
      begin
        din_a <= 1'b0;
        din_b <= 1'b0;
        pin_o <= 1'b0;
        out_b_ff <= 1'b0;
      end
      else
      begin
        if (ce_in && cfg.mode[0])
          din_a <= pin_i;
        // mode off or input only launches nothing
        if (ce_out && cfg.mode[1])
        begin
          pin_o <= dout_a;
          out_b_ff <= dout_b;
        end
      end
    end
    else if (fall)
    begin
      if (ce_in && cfg.mode[0])
        din_b <= pin_i;
      if (cfg.mode[1])
        pin_o <= out_b_ff;
    end
  end

  // driver enable; forced off whenever the cell does not drive
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      pin_oe <= 1'b0;
    else if (!cfg.mode[1])
      pin_oe <= 1'b0;
    else if (clr_act)
      pin_oe <= cfg.preset;
    else if (rise && cfg.sync_rst)
      pin_oe <= 1'b0;
    else if (rise && ce_out)
      pin_oe <= oe_drive;
  end

  // ************************************************************
  // checks
  // ************************************************************
  clear_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clr_act |=> din_a == $past(cfg.preset) && pin_o == $past(cfg.preset))
    else $error("clear did not load power-up level");
  rise_capture_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rise && !clr_act && !cfg.sync_rst && ce_in && cfg.mode[0]
    |=> din_a == $past(pin_i))
    else $error("rising capture missed");
  fall_launch_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fall && !clr_act && cfg.mode[1] |=> pin_o == $past(out_b_ff))
    else $error("second half not driven on low phase");
  sync_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rise && !clr_act && cfg.sync_rst |=> !din_a && !pin_o && !pin_oe)
    else $error("synchronous reset ignored");
  no_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !cfg.mode[1] |=> !pin_oe)
    else $error("driver on in input mode");

endmodule : prc_cell

/* hdl/prc_pkg.sv */
// constants and carriers of the row block of pin register cells
package prc_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [7:0] CFG_BASE_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MAP_END_OFS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // cell configuration
  // ************************************************************
  localparam int CFG_W = 20;
  localparam logic [19:0] CFG_RST = 20'h00000;
  localparam int ROW_MAX_CELLS = 4;
  localparam int COL_MAX_CELLS = 6;
  localparam int CTL_LINES = 4;
  localparam int STS_DIN_A_POS = 0;
  localparam int STS_DIN_B_POS = 4;
  localparam int STS_PIN_POS = 8;
  localparam int STS_OE_POS = 12;

  typedef enum logic [1:0]
  {
    PRC_MODE_OFF = 2'h0,
    PRC_MODE_IN = 2'h1,
    PRC_MODE_OUT = 2'h2,
    PRC_MODE_BIDIR = 2'h3
  } prc_mode_t;

  // polarity flips applied at the cell boundary
  typedef struct packed {
    logic clr;
    logic clk;
    logic ce;
    logic oe;
    logic dout_b;
    logic dout_a;
  } prc_inv_t;

  typedef struct packed {
    prc_inv_t inv;
    logic sync_rst;
    logic [1:0] clr_sel;
    logic [1:0] oe_sel;
    logic [1:0] ce_sel;
    logic [1:0] clk_sel;
    logic use_shared;
    logic oe_low;
    logic preset;
    prc_mode_t mode;
  } prc_cfg_t;

  typedef struct packed {
    logic clk;
    logic clr;
    logic ce_in;
    logic ce_out;
    logic oe;
    logic dout_a;
    logic dout_b;
  } prc_ctl_t;

endpackage : prc_pkg

/* hdl/prc_row_block.sv */
// row block of pin register cells with shared controls and axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - six registers per cell, both clock edges; the cell has five, with a single tristate register
// - ddr input, output or bidirectional per cell
// - one clear source, clear or preset each
// - power-up level picks clear or preset
// - all cell registers share one clear; pin_oe takes it only in the output and bidirectional modes and stays low in the off and input modes
// - synchronous reset on active clock edge
// - every cell input has local inverter; pin_i has none, and ce_in and ce_out share the one ce inverter
// - tristate active high, optionally active low
// - row holds four cells, column six
// - sixteen shared control lines per row
// - twenty-eight per-cell data and control lines
module prc_row_block
  import prc_pkg::*;
#(
  parameter int NUM_CELLS = ROW_MAX_CELLS
)
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [AXI_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [AXI_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [CTL_LINES-1:0] BLK_OE,
  input wire logic [CTL_LINES-1:0] BLK_CE,
  input wire logic [CTL_LINES-1:0] BLK_CLK,
  input wire logic [CTL_LINES-1:0] BLK_CLR,
  input wire logic [NUM_CELLS-1:0] CELL_DOUT_A,
  input wire logic [NUM_CELLS-1:0] CELL_DOUT_B,
  input wire logic [NUM_CELLS-1:0] CELL_OE,
  input wire logic [NUM_CELLS-1:0] CELL_CE_IN,
  input wire logic [NUM_CELLS-1:0] CELL_CE_OUT,
  input wire logic [NUM_CELLS-1:0] CELL_CLK,
  input wire logic [NUM_CELLS-1:0] CELL_CLR,
  input wire logic [NUM_CELLS-1:0] PIN_I,
  output logic [NUM_CELLS-1:0] PIN_O,
  output logic [NUM_CELLS-1:0] PIN_OE,
  output logic [NUM_CELLS-1:0] CELL_DIN_A,
  output logic [NUM_CELLS-1:0] CELL_DIN_B
);

  // ************************************************************
  // size check of the row
  // ************************************************************
  if (NUM_CELLS < 1 || NUM_CELLS > ROW_MAX_CELLS)
  begin : g_bad_size
    // a row may never hold more than four cells
    $error("a row holds one to four cells");
  end

  // ************************************************************
  // configuration store
  // ************************************************************
  logic [CFG_W-1:0] cfg_ff [NUM_CELLS];
  prc_cfg_t cell_cfg [NUM_CELLS];
  prc_ctl_t cell_ctl [NUM_CELLS];

  // ************************************************************
  // write channel state
  // ************************************************************
  logic aw_got_ff;
  logic w_got_ff;
  logic [AXI_ADDR_W-1:0] waddr_ff;
  logic [AXI_DATA_W-1:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic wr_cfg_hit;
  logic wr_sts_hit;
  logic [1:0] wr_idx;
  logic [AXI_DATA_W-1:0] nxt_word;

  assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID & S_AXI_WREADY;
  assign wr_do = aw_got_ff & w_got_ff & ~S_AXI_BVALID;
  assign wr_idx = waddr_ff[3:2];
  assign wr_cfg_hit = (waddr_ff[1:0] == 2'h0)
    && (waddr_ff < CFG_BASE_OFS + 8'(4 * NUM_CELLS));
  assign wr_sts_hit = (waddr_ff == STATUS_OFS);

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      aw_got_ff <= 1'b0;
      waddr_ff <= '0;
      S_AXI_AWREADY <= 1'b1;
    end
    else if (aw_take)
    begin
      aw_got_ff <= 1'b1;
      waddr_ff <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end
    else if (wr_do)
      aw_got_ff <= 1'b0;
    else if (S_AXI_BVALID && S_AXI_BREADY)
      S_AXI_AWREADY <= 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      w_got_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end
    else if (w_take)
    begin
      w_got_ff <= 1'b1;
      wdata_ff <= S_AXI_WDATA;
      wstrb_ff <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end
    else if (wr_do)
      w_got_ff <= 1'b0;
    else if (S_AXI_BVALID && S_AXI_BREADY)
      S_AXI_WREADY <= 1'b1;
  end

  // merge byte lanes into the addressed word
  always_comb
  begin
    nxt_word = {{(AXI_DATA_W-CFG_W){1'b0}}, cfg_ff[wr_idx]};
    for (int b = 0; b < 4; b++)
    begin
      if (wstrb_ff[b])
        nxt_word[8*b +: 8] = wdata_ff[8*b +: 8];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < NUM_CELLS; i++)
        cfg_ff[i] <= CFG_RST;
    end
    else if (wr_do && wr_cfg_hit)
      cfg_ff[wr_idx] <= nxt_word[CFG_W-1:0];
  end

  // status is read only; writes to it are accepted and dropped
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else if (wr_do)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (wr_cfg_hit || wr_sts_hit) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic ar_take;
  logic rd_cfg_hit;
  logic [1:0] rd_idx;
  logic [AXI_DATA_W-1:0] status_word;

  assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_idx = S_AXI_ARADDR[3:2];
  assign rd_cfg_hit = (S_AXI_ARADDR[1:0] == 2'h0)
    && (S_AXI_ARADDR < CFG_BASE_OFS + 8'(4 * NUM_CELLS));

  always_comb
  begin
    status_word = '0;
    status_word[STS_DIN_A_POS +: NUM_CELLS] = CELL_DIN_A;
    status_word[STS_DIN_B_POS +: NUM_CELLS] = CELL_DIN_B;
    status_word[STS_PIN_POS +: NUM_CELLS] = PIN_O;
    status_word[STS_OE_POS +: NUM_CELLS] = PIN_OE;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      S_AXI_ARREADY <= 1'b1;
    else if (ar_take)
      S_AXI_ARREADY <= 1'b0;
    else if (S_AXI_RVALID && S_AXI_RREADY)
      S_AXI_ARREADY <= 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      S_AXI_RVALID <= 1'b1;
      if (rd_cfg_hit)
      begin
        S_AXI_RDATA <= {{(AXI_DATA_W-CFG_W){1'b0}}, cfg_ff[rd_idx]};
        S_AXI_RRESP <= RESP_OKAY;
      end
      else if (S_AXI_ARADDR == STATUS_OFS)
      begin
        S_AXI_RDATA <= status_word;
        S_AXI_RRESP <= RESP_OKAY;
      end
      else
      begin
        S_AXI_RDATA <= '0;
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

  // ************************************************************
  // control selection and cells
  // ************************************************************
  for (genvar i = 0; i < NUM_CELLS; i++)
  begin : g_cell
    assign cell_cfg[i] = prc_cfg_t'(cfg_ff[i]);

    // shared row lines or the cell's own lines
    always_comb
    begin
      cell_ctl[i].dout_a = CELL_DOUT_A[i];
      cell_ctl[i].dout_b = CELL_DOUT_B[i];
      if (cell_cfg[i].use_shared)
      begin
        cell_ctl[i].clk = BLK_CLK[cell_cfg[i].clk_sel];
        cell_ctl[i].clr = BLK_CLR[cell_cfg[i].clr_sel];
        cell_ctl[i].oe = BLK_OE[cell_cfg[i].oe_sel];
        cell_ctl[i].ce_in = BLK_CE[cell_cfg[i].ce_sel];
        cell_ctl[i].ce_out = BLK_CE[cell_cfg[i].ce_sel];
      end
      else
      begin
        cell_ctl[i].clk = CELL_CLK[i];
        cell_ctl[i].clr = CELL_CLR[i];
        cell_ctl[i].oe = CELL_OE[i];
        cell_ctl[i].ce_in = CELL_CE_IN[i];
        cell_ctl[i].ce_out = CELL_CE_OUT[i];
      end
    end

    prc_cell u_cell
    (
      .core_clk(CORE_CLK),
      .reset_n(RESET_N),
      .cfg(cell_cfg[i]),
      .ctl(cell_ctl[i]),
      .pin_i(PIN_I[i]),
      .pin_o(PIN_O[i]),
      .pin_oe(PIN_OE[i]),
      .din_a(CELL_DIN_A[i]),
      .din_b(CELL_DIN_B[i])
    );

    oe_sense_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $rose(cell_ctl[i].clk ^ cell_cfg[i].inv.clk)
      && !(cell_ctl[i].clr ^ cell_cfg[i].inv.clr) && !cell_cfg[i].sync_rst
      && (cell_ctl[i].ce_out ^ cell_cfg[i].inv.ce) && cell_cfg[i].mode[1]
      |=> PIN_OE[i] == $past(cell_ctl[i].oe ^ cell_cfg[i].inv.oe
      ^ cell_cfg[i].oe_low))
      else $error("tristate sense wrong");

    shared_clear_a: assert property (@(posedge CORE_CLK)
      disable iff (!RESET_N)
      cell_cfg[i].use_shared
      && (BLK_CLR[cell_cfg[i].clr_sel] ^ cell_cfg[i].inv.clr)
      |=> PIN_O[i] == $past(cell_cfg[i].preset))
      else $error("shared clear did not load level");
    own_clear_a: assert property (@(posedge CORE_CLK)
      disable iff (!RESET_N)
      !cell_cfg[i].use_shared && (CELL_CLR[i] ^ cell_cfg[i].inv.clr)
      |=> CELL_DIN_A[i] == $past(cell_cfg[i].preset))
      else $error("cell clear did not load level");
  end

  // ************************************************************
  // bus checks
  // ************************************************************
  bvalid_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  write_resp_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wr_do |=> S_AXI_BVALID)
    else $error("no write response after both halves");
  cfg_store_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wr_do && wr_cfg_hit && wstrb_ff == 4'hF
    |=> cfg_ff[$past(wr_idx)] == $past(wdata_ff[CFG_W-1:0]))
    else $error("configuration write lost");
  bad_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ar_take && S_AXI_ARADDR >= MAP_END_OFS
    |=> S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == '0)
    else $error("unmapped read not refused");
  read_turn_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ar_take |=> !S_AXI_ARREADY [*1] ##0 S_AXI_RVALID)
    else $error("read answer not one cycle after address");

  // ************************************************************
  // handshake and response checks
  // ************************************************************
  aw_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    aw_got_ff |-> !S_AXI_AWREADY)
    else $error("address taken twice");
  w_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    w_got_ff |-> !S_AXI_WREADY)
    else $error("data taken twice");
  cfg_resp_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wr_do && wr_cfg_hit |=> S_AXI_BRESP == RESP_OKAY)
    else $error("configuration write refused");
  bad_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wr_do && !wr_cfg_hit && !wr_sts_hit |=> S_AXI_BRESP == RESP_SLVERR)
    else $error("unmapped write not refused");
  read_again_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    S_AXI_RVALID && S_AXI_RREADY |=> S_AXI_ARREADY)
    else $error("read address not taken again");
  status_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ar_take && S_AXI_ARADDR == STATUS_OFS
    |=> S_AXI_RDATA == $past(status_word) && S_AXI_RRESP == RESP_OKAY)
    else $error("status read wrong");

endmodule : prc_row_block

/* testbench/prc_pin_board.sv */
// board side of the pins: loops driven pins back, else an external driver
`timescale 1ns/1ps
module prc_pin_board
#(
  parameter int NUM_CELLS = 4
)
(
  input wire logic core_clk,
  input wire logic [NUM_CELLS-1:0] pin_o,
  input wire logic [NUM_CELLS-1:0] pin_oe,
  input wire logic ext_en,
  input wire logic [NUM_CELLS-1:0] ext_val,
  output logic [NUM_CELLS-1:0] pin_i
);
  logic [NUM_CELLS-1:0] last_ff = '0;
  // undriven pins have no pull, so they show a changing pattern
  always_comb
  begin
    for (int i = 0; i < NUM_CELLS; i++)
    begin
      if (pin_oe[i])
        pin_i[i] = pin_o[i];
      else if (ext_en)
        pin_i[i] = ext_val[i];
      else
        pin_i[i] = ~last_ff[i];
    end
  end
  always_ff @(posedge core_clk)
  begin
    last_ff <= pin_i;
  end
endmodule : prc_pin_board

/* testbench/prc_row_block_tb_top.sv */
// self-checking bench of the row block of pin register cells
`timescale 1ns/1ps
module prc_row_block_tb_top;
  import prc_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] blk_oe = 0, blk_ce = 0, blk_clk = 0, blk_clr = 0;
  logic [3:0] dout_a = 0, dout_b = 0, c_oe = 0, c_cein = 0, c_ceout = 0;
  logic [3:0] c_clk = 0, c_clr = 0, ext_val = 0;
  logic ext_en = 0;
  logic [3:0] pin_i, pin_o, pin_oe, din_a, din_b;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [1:0] r;
  logic [31:0] d;

  always #5 core_clk = ~core_clk;

  prc_row_block #(.NUM_CELLS(4)) prc_row_block_i (
    .CORE_CLK(core_clk), .RESET_N(reset_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .BLK_OE(blk_oe), .BLK_CE(blk_ce), .BLK_CLK(blk_clk),
    .BLK_CLR(blk_clr), .CELL_DOUT_A(dout_a), .CELL_DOUT_B(dout_b),
    .CELL_OE(c_oe), .CELL_CE_IN(c_cein), .CELL_CE_OUT(c_ceout),
    .CELL_CLK(c_clk), .CELL_CLR(c_clr), .PIN_I(pin_i), .PIN_O(pin_o),
    .PIN_OE(pin_oe), .CELL_DIN_A(din_a), .CELL_DIN_B(din_b)
  );

  prc_pin_board #(.NUM_CELLS(4)) prc_pin_board_i (
    .core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    tick(1);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    r = rresp;
    d = rdata;
    rready <= 1'b0;
    tick(1);
  endtask : axi_rd

  // moves every per-cell io clock and waits for the effect
  task automatic io_edge(input logic lvl);
    c_clk <= {4{lvl}};
    tick(3);
  endtask : io_edge

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs;
    check({pin_o, pin_oe, din_a, din_b}, 16'h0000);
    axi_rd(8'h00);
    check(d, 32'h0);
    axi_wr(8'h0C, 32'hFFFF0000);
    check(r, RESP_OKAY);
    axi_rd(8'h0C);
    check(d, 32'h000F0000);
    axi_wr(8'h0C, 32'h0);
    axi_wr(8'h14, 32'h1);
    check(r, RESP_SLVERR);
    axi_rd(8'h14);
    check(r, RESP_SLVERR);
    check(d, 32'h0);
    axi_rd(8'h02);
    check(r, RESP_SLVERR);
    axi_wr(8'h10, 32'hFFFF);
    check(r, RESP_OKAY);
  endtask : t_regs

  task automatic t_modes;
    axi_wr(8'h00, 32'h2);
    axi_wr(8'h04, 32'h1);
    axi_wr(8'h08, 32'h3);
    c_cein <= 4'hF;
    c_ceout <= 4'hF;
    c_oe <= 4'hF;
    dout_a <= 4'hF;
    ext_en <= 1'b1;
    ext_val <= 4'hF;
    io_edge(1'b1);
    check(pin_o & 4'hD, 4'h5);
    check(pin_oe, 4'h5);
    check(din_a, 4'h6);
    dout_b <= 4'hF;
    ext_val <= 4'h0;
    io_edge(1'b0);
    check(pin_o & 4'hD, 4'h0);
    check(din_b, 4'h4);
    axi_rd(STATUS_OFS);
    check(d & 32'hFFFFFDBF, 32'h5006);
  endtask : t_modes

  task automatic t_polarity;
    axi_wr(8'h00, 32'h400A);
    io_edge(1'b1);
    check(pin_o[0], 1'b0);
    check(pin_oe[0], 1'b0);
  endtask : t_polarity

  task automatic t_clear;
    axi_wr(8'h00, 32'h6);
    c_clr <= 4'h1;
    tick(3);
    check({pin_o[0], pin_oe[0], din_a[0], din_b[0]}, 4'hF);
    c_clr <= 4'h0;
    axi_wr(8'h00, 32'h2002);
    io_edge(1'b0);
    io_edge(1'b1);
    check({pin_o[0], din_a[0], din_b[0]}, 3'h0);
  endtask : t_clear

  task automatic t_shared;
    axi_wr(8'h00, 32'h6D2);
    blk_ce <= 4'h2;
    blk_oe <= 4'h8;
    c_clk <= 4'h0;
    tick(3);
    blk_clk <= 4'h4;
    tick(3);
    check({pin_o[0], pin_oe[0]}, 2'h3);
    blk_clr <= 4'h1;
    tick(3);
    check({pin_o[0], pin_oe[0]}, 2'h0);
  endtask : t_shared

  // ************************************************************
  // run control
  // ************************************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  initial
  begin
    tick(5);
    reset_n <= 1'b1;
    tick(1);
    t_regs();
    t_modes();
    t_polarity();
    t_clear();
    t_shared();
    give_verdict();
  end
endmodule : prc_row_block_tb_top
